/* hw/cfl_cfg.svh */
`ifndef CFL_CFG_SVH
`define CFL_CFG_SVH

// Link address: index in [7:2], channel in [1:0]
`define CFL_IDX_ROLE 6'h00
`define CFL_IDX_ADC 6'h01
`define CFL_IDX_DIN_A 6'h02
`define CFL_IDX_DIN_B 6'h03
`define CFL_IDX_RES 6'h04
`define CFL_IDX_OUT 6'h05
`define CFL_IDX_DAC 6'h06
`define CFL_IDX_ALERT 6'h08

// Field positions in the 16-bit link data
`define CFL_ADC_MUX_LSB 0
`define CFL_ADC_RNG_LSB 4
`define CFL_DINA_THR_LSB 0
`define CFL_DINA_CMP_BIT 8
`define CFL_DINA_INV_BIT 9
`define CFL_DINA_SINK_BIT 10
`define CFL_DINB_TMODE_BIT 0
`define CFL_RES_WIRE_BIT 0
`define CFL_RES_CUR_LSB 1
`define CFL_RES_REF_BIT 3
`define CFL_OUT_SUP_LSB 0
`define CFL_ALERT_POR_BIT 0

// Default field values
`define CFL_MUX_LF_GND 3'h0
`define CFL_MUX_HF_LF 3'h1
`define CFL_MUX_LF_VSN 3'h3
`define CFL_RNG_0_12V 3'h0
`define CFL_RNG_BIPOLAR_LOW 3'h2
`define CFL_RNG_NEG_LOW 3'h3
`define CFL_RNG_POS_LOW 3'h4
`define CFL_RNG_RES 3'h5
`define CFL_THR_HALF 7'h49
`define CFL_THR_ZERO 7'h00
`define CFL_SUP_LOCK 2'h0
`define CFL_SUP_TRACK 2'h2
`define CFL_WIRE_THREE 1'h0
`define CFL_CUR_1MA 2'h1
`define CFL_REF_2V 1'h0

// Host register map (APB byte addresses)
`define CFL_APB_CMD 12'h000
`define CFL_APB_STATUS 12'h004
`define CFL_ALERT_ALL 16'hffff

// Timing
`define CFL_CLK_NS 40
`define CFL_T_INIT_NS 300000
`define CFL_T_INIT_MODEM_NS 4200000

`endif

/* hw/cfl_pkg.sv */
package cfl_pkg;

  typedef enum logic [3:0] {
    role_float = 4'h0,
    role_voltage_drive = 4'h1,
    role_current_drive = 4'h2,
    role_voltage_sense = 4'h3,
    role_current_sense_ext = 4'h4,
    role_current_sense_loop = 4'h5,
    role_resistance_sense = 4'h7,
    role_logic_in = 4'h8,
    role_loop_logic_in = 4'h9,
    role_current_drive_modem = 4'ha,
    role_current_sense_ext_modem = 4'hb,
    role_current_sense_loop_modem = 4'hc
  } cfl_role_e;

  typedef struct packed {
    logic [2:0] mux;
    logic [2:0] span;
    logic detector_on;
    logic invert;
    logic [6:0] thresh;
    logic [1:0] supply;
  } cfl_defaults_s;

  typedef enum logic [6:0] {
    st_clear = 7'h01,
    st_idle = 7'h02,
    st_float = 7'h04,
    st_dac = 7'h08,
    st_settle = 7'h10,
    st_role = 7'h20,
    st_init = 7'h40
  } cfl_host_state_e;

  typedef logic [15:0] cfl_data_t;

endpackage : cfl_pkg

/* hw/cfl_link_if.sv */
`timescale 1ns/1ps
`default_nettype none

interface cfl_link_if;
  logic req;
  logic we;
  logic [7:0] addr;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic ack;
  logic alert_n;

  modport dev (
    input req,
    input we,
    input addr,
    input wdata,
    output rdata,
    output ack,
    output alert_n
  );

  modport host (
    output req,
    output we,
    output addr,
    output wdata,
    input rdata,
    input ack,
    input alert_n
  );
endinterface : cfl_link_if

`default_nettype wire

/* hw/cfl_device.sv */
// Register access over APB and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "cfl_cfg.svh"
// Notes on behaviour
// - Reset sets power-on flag, alert low
// - Alert flags clear on written one
// - Host clears alert flags after power-up
// - Role write loads that channel's defaults
// - Any role: three-wire, 1mA, 2V reference
// - Any role: sink off, threshold scales supply
// - Four-bit role code decode table
// - External current sense defaults
// - Loop current sense defaults, inverted
// - Current drive defaults, tracking supply
// - Logic input defaults, half-supply threshold
// - Float, voltage, resistance defaults
// - Host floats channel before new role
// - Host holds role for init time
// - Role change keeps DAC code
// - Host writes intended DAC code first
// - Bipolar drive starts at mid-scale code; host writes the command's DAC code as given
// - Host waits init time after DAC, before role
// - Float, DAC, wait, role, wait sequence

module cfl_device #(
  parameter int CHANNELS = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  cfl_link_if.dev link,
  output logic [CHANNELS*4-1:0] role_code_flat,
  output logic [CHANNELS-1:0] detector_on_flat,
  output logic [CHANNELS*16-1:0] dac_code_flat
);
  import cfl_pkg::*;

  generate
    if (CHANNELS < 1 || CHANNELS > 4)
    begin : g_bad_channels
      $error("CHANNELS must be 1 to 4");
    end
  endgenerate

  function automatic cfl_defaults_s role_defaults(input logic [3:0] code);
    cfl_defaults_s d;
    d.mux = `CFL_MUX_LF_GND;
    d.span = `CFL_RNG_0_12V;
    d.detector_on = 1'b0;
    d.invert = 1'b0;
    d.thresh = `CFL_THR_ZERO;
    d.supply = `CFL_SUP_LOCK;
    case (code)
      role_voltage_drive:
      begin
        d.mux = `CFL_MUX_HF_LF;
        d.span = `CFL_RNG_BIPOLAR_LOW;
      end
      role_current_drive, role_current_drive_modem:
      begin
        d.supply = `CFL_SUP_TRACK;
      end
      role_current_sense_ext, role_current_sense_ext_modem:
      begin
        d.mux = `CFL_MUX_HF_LF;
        d.span = `CFL_RNG_NEG_LOW;
        d.detector_on = 1'b1;
        d.thresh = `CFL_THR_HALF;
      end
      role_current_sense_loop, role_current_sense_loop_modem:
      begin
        d.mux = `CFL_MUX_HF_LF;
        d.span = `CFL_RNG_POS_LOW;
        d.detector_on = 1'b1;
        d.invert = 1'b1;
        d.thresh = `CFL_THR_HALF;
      end
      role_resistance_sense:
      begin
        d.mux = `CFL_MUX_LF_VSN;
        d.span = `CFL_RNG_RES;
      end
      role_logic_in, role_loop_logic_in:
      begin
        d.detector_on = 1'b1;
        d.thresh = `CFL_THR_HALF;
      end
      default:
      begin
        // Float, voltage sense and every undefined code keep the float set
        d.mux = `CFL_MUX_LF_GND;
      end
    endcase
    return d;
  endfunction : role_defaults

  logic [3:0] role_reg [CHANNELS];
  logic [3:0] role_next [CHANNELS];
  logic [2:0] mux_reg [CHANNELS];
  logic [2:0] mux_next [CHANNELS];
  logic [2:0] span_reg [CHANNELS];
  logic [2:0] span_next [CHANNELS];
  logic det_reg [CHANNELS];
  logic det_next [CHANNELS];
  logic inv_reg [CHANNELS];
  logic inv_next [CHANNELS];
  logic [6:0] thr_reg [CHANNELS];
  logic [6:0] thr_next [CHANNELS];
  logic sink_reg [CHANNELS];
  logic sink_next [CHANNELS];
  logic tmode_reg [CHANNELS];
  logic tmode_next [CHANNELS];
  logic wire_reg [CHANNELS];
  logic wire_next [CHANNELS];
  logic [1:0] cur_reg [CHANNELS];
  logic [1:0] cur_next [CHANNELS];
  logic ref_reg [CHANNELS];
  logic ref_next [CHANNELS];
  logic [1:0] sup_reg [CHANNELS];
  logic [1:0] sup_next [CHANNELS];
  logic [15:0] dac_reg [CHANNELS];
  logic [15:0] dac_next [CHANNELS];
  logic por_flag_reg;
  logic por_flag_next;
  logic alert_n_reg;
  logic alert_n_next;
  logic ack_reg;
  logic ack_next;
  cfl_data_t rdata_reg;
  cfl_data_t rdata_next;

  logic take;
  logic [5:0] idx;
  logic [1:0] ch;
  cfl_defaults_s dflt;

  assign take = link.req && !ack_reg;
  assign idx = link.addr[7:2];
  assign ch = link.addr[1:0];
  assign dflt = role_defaults(link.wdata[3:0]);

  always_comb
  begin
    role_next = role_reg;
    mux_next = mux_reg;
    span_next = span_reg;
    det_next = det_reg;
    inv_next = inv_reg;
    thr_next = thr_reg;
    sink_next = sink_reg;
    tmode_next = tmode_reg;
    wire_next = wire_reg;
    cur_next = cur_reg;
    ref_next = ref_reg;
    sup_next = sup_reg;
    dac_next = dac_reg;
    por_flag_next = por_flag_reg;
    ack_next = take;
    rdata_next = rdata_reg;
    for (int c = 0; c < CHANNELS; c++)
    begin
      if (take && link.we && ch == 2'(c))
      begin
        unique case (idx)
          `CFL_IDX_ROLE:
          begin
            // Every dependent field moves in this cycle; DAC is left alone
            role_next[c] = link.wdata[3:0];
            mux_next[c] = dflt.mux;
            span_next[c] = dflt.span;
            det_next[c] = dflt.detector_on;
            inv_next[c] = dflt.invert;
            thr_next[c] = dflt.thresh;
            sup_next[c] = dflt.supply;
            wire_next[c] = `CFL_WIRE_THREE;
            cur_next[c] = `CFL_CUR_1MA;
            ref_next[c] = `CFL_REF_2V;
            sink_next[c] = 1'b0;
            tmode_next[c] = 1'b0;
          end
          `CFL_IDX_ADC:
          begin
            mux_next[c] = link.wdata[`CFL_ADC_MUX_LSB +: 3];
            span_next[c] = link.wdata[`CFL_ADC_RNG_LSB +: 3];
          end
          `CFL_IDX_DIN_A:
          begin
            thr_next[c] = link.wdata[`CFL_DINA_THR_LSB +: 7];
            det_next[c] = link.wdata[`CFL_DINA_CMP_BIT];
            inv_next[c] = link.wdata[`CFL_DINA_INV_BIT];
            sink_next[c] = link.wdata[`CFL_DINA_SINK_BIT];
          end
          `CFL_IDX_DIN_B: tmode_next[c] = link.wdata[`CFL_DINB_TMODE_BIT];
          `CFL_IDX_RES:
          begin
            wire_next[c] = link.wdata[`CFL_RES_WIRE_BIT];
            cur_next[c] = link.wdata[`CFL_RES_CUR_LSB +: 2];
            ref_next[c] = link.wdata[`CFL_RES_REF_BIT];
          end
          `CFL_IDX_OUT: sup_next[c] = link.wdata[`CFL_OUT_SUP_LSB +: 2];
          `CFL_IDX_DAC: dac_next[c] = link.wdata;
          default:
          begin
            dac_next[c] = dac_reg[c];
          end
        endcase
      end
      if (take && !link.we && ch == 2'(c))
      begin
        rdata_next = '0;
        unique case (idx)
          `CFL_IDX_ROLE: rdata_next[3:0] = role_reg[c];
          `CFL_IDX_ADC:
          begin
            rdata_next[`CFL_ADC_MUX_LSB +: 3] = mux_reg[c];
            rdata_next[`CFL_ADC_RNG_LSB +: 3] = span_reg[c];
          end
          `CFL_IDX_DIN_A:
          begin
            rdata_next[`CFL_DINA_THR_LSB +: 7] = thr_reg[c];
            rdata_next[`CFL_DINA_CMP_BIT] = det_reg[c];
            rdata_next[`CFL_DINA_INV_BIT] = inv_reg[c];
            rdata_next[`CFL_DINA_SINK_BIT] = sink_reg[c];
          end
          `CFL_IDX_DIN_B: rdata_next[`CFL_DINB_TMODE_BIT] = tmode_reg[c];
          `CFL_IDX_RES:
          begin
            rdata_next[`CFL_RES_WIRE_BIT] = wire_reg[c];
            rdata_next[`CFL_RES_CUR_LSB +: 2] = cur_reg[c];
            rdata_next[`CFL_RES_REF_BIT] = ref_reg[c];
          end
          `CFL_IDX_OUT: rdata_next[`CFL_OUT_SUP_LSB +: 2] = sup_reg[c];
          `CFL_IDX_DAC: rdata_next = dac_reg[c];
          default: rdata_next = '0;
        endcase
      end
    end
    if (take && idx == `CFL_IDX_ALERT)
    begin
      if (link.we)
      begin
        // Writing zero leaves the flag; nothing in hardware sets it again
        por_flag_next = por_flag_reg & ~link.wdata[`CFL_ALERT_POR_BIT];
      end
      else
      begin
        rdata_next = '0;
        rdata_next[`CFL_ALERT_POR_BIT] = por_flag_reg;
      end
    end
    alert_n_next = !por_flag_next;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int c = 0; c < CHANNELS; c++)
      begin
        role_reg[c] <= 4'h0;
        mux_reg[c] <= `CFL_MUX_LF_GND;
        span_reg[c] <= `CFL_RNG_0_12V;
        det_reg[c] <= 1'b0;
        inv_reg[c] <= 1'b0;
        thr_reg[c] <= `CFL_THR_ZERO;
        sink_reg[c] <= 1'b0;
        tmode_reg[c] <= 1'b0;
        wire_reg[c] <= `CFL_WIRE_THREE;
        cur_reg[c] <= `CFL_CUR_1MA;
        ref_reg[c] <= `CFL_REF_2V;
        sup_reg[c] <= `CFL_SUP_LOCK;
        dac_reg[c] <= 16'h0000;
      end
      por_flag_reg <= 1'b1;
      alert_n_reg <= 1'b0;
      ack_reg <= 1'b0;
      rdata_reg <= 16'h0000;
    end
    else
    begin
      role_reg <= role_next;
      mux_reg <= mux_next;
      span_reg <= span_next;
      det_reg <= det_next;
      inv_reg <= inv_next;
      thr_reg <= thr_next;
      sink_reg <= sink_next;
      tmode_reg <= tmode_next;
      wire_reg <= wire_next;
      cur_reg <= cur_next;
      ref_reg <= ref_next;
      sup_reg <= sup_next;
      dac_reg <= dac_next;
      por_flag_reg <= por_flag_next;
      alert_n_reg <= alert_n_next;
      ack_reg <= ack_next;
      rdata_reg <= rdata_next;
    end
  end

  assign link.ack = ack_reg;
  assign link.rdata = rdata_reg;
  assign link.alert_n = alert_n_reg;

  for (genvar c = 0; c < CHANNELS; c++)
  begin : g_flat
    assign role_code_flat[c*4 +: 4] = role_reg[c];
    assign detector_on_flat[c] = det_reg[c];
    assign dac_code_flat[c*16 +: 16] = dac_reg[c];
  end

endmodule : cfl_device

`default_nettype wire

/* hw/cfl_host.sv */
`timescale 1ns/1ps
`default_nettype none
`include "cfl_cfg.svh"

module cfl_host #(
  parameter int SETTLE_CYC = (`CFL_T_INIT_NS + `CFL_CLK_NS - 1) / `CFL_CLK_NS,
  parameter int INIT_CYC = (`CFL_T_INIT_NS + `CFL_CLK_NS - 1) / `CFL_CLK_NS,
  parameter int INIT_MODEM_CYC = (`CFL_T_INIT_MODEM_NS + `CFL_CLK_NS - 1) / `CFL_CLK_NS
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  cfl_link_if.host link
);
  import cfl_pkg::*;

  generate
    if (SETTLE_CYC < 1 || INIT_CYC < 1 || INIT_MODEM_CYC < 1 || INIT_MODEM_CYC > 16777215)
    begin : g_bad_timing
      $error("Wait counts must be 1 to 2**24-1");
    end
  endgenerate

  cfl_host_state_e state_reg, state_next;
  logic [23:0] timer_reg, timer_next;
  logic [3:0] role_reg, role_next;
  logic [1:0] ch_reg, ch_next;
  logic [15:0] dac_reg, dac_next;
  logic req_reg, req_next;
  logic we_reg, we_next;
  logic [7:0] addr_reg, addr_next;
  logic [15:0] wdata_reg, wdata_next;
  logic [31:0] prdata_reg, prdata_next;
  logic pready_reg, pready_next;
  logic pslverr_reg, pslverr_next;
  logic busy;
  logic cmd_wr;
  logic link_done;

  assign busy = (state_reg != st_idle);
  assign cmd_wr = psel && penable && pready_reg && pwrite && paddr == `CFL_APB_CMD && !busy;
  assign link_done = req_reg && link.ack;

  always_comb
  begin
    pready_next = psel && !penable && !pready_reg;
    pslverr_next = 1'b0;
    prdata_next = prdata_reg;
    if (psel && !penable)
    begin
      prdata_next = 32'h0000_0000;
      if (paddr == `CFL_APB_STATUS)
      begin
        prdata_next[0] = busy;
        prdata_next[1] = (state_reg != st_clear);
        prdata_next[2] = !link.alert_n;
        prdata_next[7:4] = role_reg;
        prdata_next[9:8] = ch_reg;
      end
      else if (paddr == `CFL_APB_CMD)
      begin
        prdata_next = {dac_reg, 10'h000, ch_reg, role_reg};
        // A new order while a sequence runs is refused
        pslverr_next = pwrite && busy;
      end
      else
      begin
        pslverr_next = 1'b1;
      end
    end
  end

  always_comb
  begin
    state_next = state_reg;
    timer_next = timer_reg;
    role_next = role_reg;
    ch_next = ch_reg;
    dac_next = dac_reg;
    req_next = req_reg;
    we_next = we_reg;
    addr_next = addr_reg;
    wdata_next = wdata_reg;
    if (link_done)
    begin
      req_next = 1'b0;
    end
    unique case (state_reg)
      st_clear:
      begin
        if (!req_reg)
        begin
          req_next = 1'b1;
          we_next = 1'b1;
          addr_next = {`CFL_IDX_ALERT, 2'h0};
          wdata_next = `CFL_ALERT_ALL;
        end
        else if (link_done)
        begin
          state_next = st_idle;
        end
      end
      st_idle:
      begin
        if (cmd_wr)
        begin
          role_next = pwdata[3:0];
          ch_next = pwdata[5:4];
          dac_next = pwdata[31:16];
          state_next = st_float;
        end
      end
      st_float:
      begin
        if (!req_reg)
        begin
          req_next = 1'b1;
          we_next = 1'b1;
          addr_next = {`CFL_IDX_ROLE, ch_reg};
          wdata_next = 16'h0000;
        end
        else if (link_done)
        begin
          state_next = st_dac;
        end
      end
      st_dac:
      begin
        if (!req_reg)
        begin
          // Software supplies the code: zero for outputs, mid-scale for bipolar drive
          req_next = 1'b1;
          we_next = 1'b1;
          addr_next = {`CFL_IDX_DAC, ch_reg};
          wdata_next = dac_reg;
        end
        else if (link_done)
        begin
          state_next = st_settle;
          timer_next = 24'(SETTLE_CYC - 1);
        end
      end
      st_settle:
      begin
        if (timer_reg == 24'h000000)
        begin
          state_next = st_role;
        end
        else
        begin
          timer_next = timer_reg - 24'h000001;
        end
      end
      st_role:
      begin
        if (!req_reg)
        begin
          req_next = 1'b1;
          we_next = 1'b1;
          addr_next = {`CFL_IDX_ROLE, ch_reg};
          wdata_next = {12'h000, role_reg};
        end
        else if (link_done)
        begin
          state_next = st_init;
          if (role_reg == role_current_drive_modem)
          begin
            timer_next = 24'(INIT_MODEM_CYC - 1);
          end
          else
          begin
            timer_next = 24'(INIT_CYC - 1);
          end
        end
      end
      st_init:
      begin
        // Busy holds off the next order, so the role stays for its init time
        if (timer_reg == 24'h000000)
        begin
          state_next = st_idle;
        end
        else
        begin
          timer_next = timer_reg - 24'h000001;
        end
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_reg <= st_clear;
      timer_reg <= 24'h000000;
      role_reg <= 4'h0;
      ch_reg <= 2'h0;
      dac_reg <= 16'h0000;
      req_reg <= 1'b0;
      we_reg <= 1'b0;
      addr_reg <= 8'h00;
      wdata_reg <= 16'h0000;
      prdata_reg <= 32'h0000_0000;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      timer_reg <= timer_next;
      role_reg <= role_next;
      ch_reg <= ch_next;
      dac_reg <= dac_next;
      req_reg <= req_next;
      we_reg <= we_next;
      addr_reg <= addr_next;
      wdata_reg <= wdata_next;
      prdata_reg <= prdata_next;
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
    end
  end

  assign link.req = req_reg;
  assign link.we = we_reg;
  assign link.addr = addr_reg;
  assign link.wdata = wdata_reg;
  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;

endmodule : cfl_host

`default_nettype wire

/* bench/cfl_asserts.sv */
`timescale 1ns/1ps
`default_nettype none

module cfl_asserts #(
  parameter int SETTLE_CYC = 8,
  parameter int INIT_CYC = 8,
  parameter int INIT_MODEM_CYC = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic req,
  input wire logic we,
  input wire logic [7:0] addr,
  input wire logic [15:0] wdata,
  input wire logic [15:0] rdata,
  input wire logic ack,
  input wire logic alert_n
);
  // Slack absorbs where the host starts counting its waits
  localparam int SLACK = 2;
  logic [31:0] since_dac_reg;
  logic [31:0] since_role_reg;
  logic [3:0] floated_reg;
  logic modem_reg;
  logic role_wr;
  logic dac_wr;
  assign role_wr = req && we && addr[7:2] == 6'h00;
  assign dac_wr = req && we && addr[7:2] == 6'h06;
  // Role age starts large so the first role after reset is legal
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      since_dac_reg <= '0;
      since_role_reg <= 32'h0010_0000;
      floated_reg <= '1;
      modem_reg <= 1'b0;
    end
    else
    begin
      since_dac_reg <= (dac_wr && ack) ? '0 : since_dac_reg + 32'd1;
      since_role_reg <= (role_wr && ack) ? '0 : since_role_reg + 32'd1;
      if (role_wr && ack)
      begin
        floated_reg[addr[1:0]] <= (wdata[3:0] == 4'h0);
        modem_reg <= (wdata[3:0] == 4'ha);
      end
    end
  end
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence s_take;
    req && !ack;
  endsequence
  sequence s_clear_done;
    req && we && addr[7:2] == 6'h08 && wdata[0] && !ack ##1 ack;
  endsequence
  AST_ACK_NEXT: assert property (s_take |=> ack)
    else $error("ack missing after request");
  AST_ACK_PULSE: assert property (ack |=> !ack)
    else $error("ack longer than one cycle");
  AST_ACK_CAUSE: assert property (ack |-> $past(req) && !$past(ack))
    else $error("ack without request");
  AST_RDATA_HOLD: assert property (!ack |-> $stable(rdata))
    else $error("read data moved without ack");
  AST_REQ_HOLD: assert property (s_take |=> req && $stable(addr) && $stable(wdata))
    else $error("request changed before ack");
  AST_ALERT_POR: assert property ($rose(presetn) |-> !alert_n)
    else $error("alert not low after reset");
  AST_ALERT_HOLD: assert property (!alert_n && !(req && !ack && we && addr[7:2] == 6'h08)
    |=> !alert_n)
    else $error("alert released without write");
  AST_ALERT_CLEAR: assert property (s_clear_done |=> alert_n)
    else $error("alert not cleared by written one");
  AST_CLEAR_START: assert property ($rose(presetn) |->
    ##[1:4] (req && we && addr[7:2] == 6'h08 && wdata == 16'hffff))
    else $error("no alert clear after reset");
  AST_FLOAT_FIRST: assert property (s_take and role_wr && wdata[3:0] != 4'h0
    |-> floated_reg[addr[1:0]])
    else $error("role set without float first");
  AST_SETTLE: assert property (s_take and role_wr && wdata[3:0] != 4'h0
    |-> since_dac_reg + SLACK >= SETTLE_CYC)
    else $error("role written too soon after dac");
  AST_ROLE_HOLD: assert property (s_take and role_wr
    |-> since_role_reg + SLACK >= (modem_reg ? INIT_MODEM_CYC : INIT_CYC))
    else $error("role changed too soon");
endmodule : cfl_asserts

`default_nettype wire

/* bench/channel_function_defaults_loader_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none

module channel_function_defaults_loader_tb_top;
  import cfl_pkg::*;
  localparam int SETTLE = 8;
  localparam int INIT = 8;
  localparam int INIT_MODEM = 16;
  logic pclk;
  logic presetn;
  logic psel;
  logic penable;
  logic pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [15:0] role_flat;
  logic [3:0] det_flat;
  logic [63:0] dac_flat;
  int error_cnt = 0;
  int n_compared = 0;
  int cyc = 0;
  cfl_link_if link();
  cfl_link_if link_b();
  cfl_host #(.SETTLE_CYC(SETTLE), .INIT_CYC(INIT), .INIT_MODEM_CYC(INIT_MODEM)) u_cfl_host (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .link(link));
  cfl_device u_cfl_device (.pclk(pclk), .presetn(presetn), .link(link),
    .role_code_flat(role_flat), .detector_on_flat(det_flat), .dac_code_flat(dac_flat));
  // Second device is driven directly so field reads and bad orders are reachable
  cfl_device u_cfl_device_b (.pclk(pclk), .presetn(presetn), .link(link_b),
    .role_code_flat(), .detector_on_flat(), .dac_code_flat());
  cfl_asserts #(.SETTLE_CYC(SETTLE), .INIT_CYC(INIT), .INIT_MODEM_CYC(INIT_MODEM))
    u_cfl_asserts (.pclk(pclk), .presetn(presetn), .req(link.req), .we(link.we),
    .addr(link.addr), .wdata(link.wdata), .rdata(link.rdata), .ack(link.ack),
    .alert_n(link.alert_n));
  initial
  begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  always @(posedge pclk) cyc <= cyc + 1;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic report_and_stop;
    $display("Compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : report_and_stop
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
    output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // Only the watchdog ends a wait for the slave
    while (pready !== 1'b1)
      @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic lk(input logic w, input logic [7:0] a, input logic [15:0] d,
    output logic [15:0] rd);
    @(posedge pclk);
    link_b.req <= 1'b1;
    link_b.we <= w;
    link_b.addr <= a;
    link_b.wdata <= d;
    @(posedge pclk);
    while (link_b.ack !== 1'b1)
      @(posedge pclk);
    rd = link_b.rdata;
    // Released address and data show the inverse, not the last value; we keeps its last value
    link_b.req <= 1'b0;
    link_b.addr <= ~a;
    link_b.wdata <= ~d;
  endtask : lk
  function automatic cfl_defaults_s exp_def(input logic [3:0] c);
    case (c)
      4'h1: exp_def = '{3'h1, 3'h2, 1'b0, 1'b0, 7'h00, 2'h0};
      4'h2, 4'ha: exp_def = '{3'h0, 3'h0, 1'b0, 1'b0, 7'h00, 2'h2};
      4'h4, 4'hb: exp_def = '{3'h1, 3'h3, 1'b1, 1'b0, 7'h49, 2'h0};
      4'h5, 4'hc: exp_def = '{3'h1, 3'h4, 1'b1, 1'b1, 7'h49, 2'h0};
      4'h7: exp_def = '{3'h3, 3'h5, 1'b0, 1'b0, 7'h00, 2'h0};
      4'h8, 4'h9: exp_def = '{3'h0, 3'h0, 1'b1, 1'b0, 7'h49, 2'h0};
      default: exp_def = '{3'h0, 3'h0, 1'b0, 1'b0, 7'h00, 2'h0};
    endcase
  endfunction : exp_def
  task automatic t_startup;
    logic [31:0] rd;
    logic err;
    int n;
    n = 0;
    rd = '0;
    while (rd[1] !== 1'b1 && n < 20)
    begin
      apb(1'b0, 12'h004, 32'h0, rd, err);
      n++;
    end
    check(rd[1], 1'b1);
    check(link.alert_n, 1'b1);
    $display("startup test done");
  endtask : t_startup
  task automatic t_alert_b;
    logic [15:0] rd;
    check(link_b.alert_n, 1'b0);
    lk(1'b1, 8'h20, 16'hfffe, rd);
    repeat (2) @(posedge pclk);
    check(link_b.alert_n, 1'b0);
    lk(1'b1, 8'h20, 16'h0001, rd);
    repeat (2) @(posedge pclk);
    check(link_b.alert_n, 1'b1);
    lk(1'b0, 8'h20, 16'h0000, rd);
    check(rd & 16'h0001, 16'h0000);
    $display("alert flag test done");
  endtask : t_alert_b
  task automatic t_defaults;
    logic [15:0] rd;
    logic [15:0] r [7];
    logic [1:0] ch;
    cfl_defaults_s e;
    for (int c = 0; c < 16; c++)
    begin
      ch = 2'(c);
      e = exp_def(4'(c));
      lk(1'b1, {6'h00, ch}, 16'h0000, rd);
      for (int i = 1; i < 6; i++)
        lk(1'b1, {6'(i), ch}, 16'h07ff, rd);
      lk(1'b1, {6'h06, ch}, 16'h1230 + 16'(c), rd);
      lk(1'b1, {6'h00, ch}, 16'(c), rd);
      for (int i = 0; i < 7; i++)
      begin
        lk(1'b0, {6'(i), ch}, 16'h0000, rd);
        r[i] = rd;
      end
      check(r[0] & 16'h000f, 16'(c));
      check(r[1] & 16'h0077, {9'h0, e.span, 1'b0, e.mux});
      check(r[2] & 16'h07ff, {6'h0, e.invert, e.detector_on, 1'b0, e.thresh});
      check(r[3] & 16'h0001, 16'h0000);
      check(r[4] & 16'h000f, 16'h0002);
      check(r[5] & 16'h0003, {14'h0, e.supply});
      check(r[6], 16'h1230 + 16'(c));
    end
    $display("defaults test done");
  endtask : t_defaults
  task automatic wait_idle(output int t);
    logic [31:0] rd;
    logic err;
    int n;
    t = cyc;
    n = 0;
    rd = 32'h1;
    while (rd[0] !== 1'b0 && n < 200)
    begin
      apb(1'b0, 12'h004, 32'h0, rd, err);
      n++;
    end
    t = cyc - t;
    check(rd[0], 1'b0);
  endtask : wait_idle
  task automatic t_cmd;
    logic [31:0] rd;
    logic err;
    int t;
    apb(1'b1, 12'h000, 32'h8000_001a, rd, err);
    check(err, 1'b0);
    apb(1'b1, 12'h000, 32'h0000_0025, rd, err);
    check(err, 1'b1);
    wait_idle(t);
    check(t >= SETTLE + INIT_MODEM, 1'b1);
    check(role_flat[7:4], 4'ha);
    check(dac_flat[31:16], 16'h8000);
    check(det_flat[1], 1'b0);
    apb(1'b0, 12'h004, 32'h0, rd, err);
    check(rd[9:4], 6'h1a);
    apb(1'b1, 12'h000, 32'h0000_0025, rd, err);
    wait_idle(t);
    check(role_flat[11:8], 4'h5);
    check(det_flat[2], 1'b1);
    check(dac_flat[47:32], 16'h0000);
    check(dac_flat[31:16], 16'h8000);
    apb(1'b0, 12'h000, 32'h0, rd, err);
    check(rd, 32'h0000_0025);
    apb(1'b0, 12'h008, 32'h0, rd, err);
    check(err, 1'b1);
    check(rd, 32'h0);
    $display("command sequence test done");
  endtask : t_cmd
  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    link_b.req = 1'b0;
    link_b.we = 1'b0;
    link_b.addr = '0;
    link_b.wdata = '0;
    repeat (16) @(posedge pclk);
    check(link.alert_n, 1'b0);
    presetn <= 1'b1;
    t_startup;
    t_alert_b;
    t_defaults;
    t_cmd;
    report_and_stop;
  end
  initial
  begin
    repeat (20000) @(posedge pclk);
    error_cnt++;
    report_and_stop;
  end
endmodule : channel_function_defaults_loader_tb_top

`default_nettype wire
